// *** rvc_pkg.sv ***
// constants shared by the regulator configuration command bank
package rvc_pkg;

   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_RUN_CTRL = 8'h01;
   localparam logic [7:0] CMD_ON_SRC = 8'h02;
   localparam logic [7:0] CMD_CLR_FAULT = 8'h03;
   localparam logic [7:0] CMD_STORE_ALL = 8'h15;
   localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
   localparam logic [7:0] CMD_VOUT_FMT = 8'h20;
   localparam logic [7:0] CMD_SETPOINT = 8'h21;
   localparam logic [7:0] CMD_VTRIM = 8'h23;
   localparam logic [7:0] CMD_CEILING = 8'h24;
   localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
   localparam logic [7:0] CMD_SLEW = 8'h27;
   localparam logic [7:0] CMD_LOAD_LINE = 8'h28;
   localparam logic [7:0] CMD_SW_RATE = 8'h33;
   localparam logic [7:0] CMD_PHASE = 8'h37;
   localparam logic [7:0] CMD_CS_GAIN = 8'h38;
   localparam logic [7:0] CMD_CS_TRIM = 8'h39;
   localparam logic [7:0] CMD_OV_FLT = 8'h40;
   localparam logic [7:0] CMD_OV_ACT = 8'h41;
   localparam logic [7:0] CMD_OV_WARN = 8'h42;
   localparam logic [7:0] CMD_UV_WARN = 8'h43;
   localparam logic [7:0] CMD_UV_FLT = 8'h44;
   localparam logic [7:0] CMD_UV_ACT = 8'h45;
   localparam logic [7:0] CMD_OC_FLT = 8'h46;
   localparam logic [7:0] CMD_UC_FLT = 8'h4b;
   localparam logic [7:0] CMD_OT_FLT = 8'h4f;

   // ----------------------------------------
   // register file slots
   // ----------------------------------------
   localparam int NREG = 22;
   localparam logic [4:0] IDX_RUN = 5'h00, IDX_ONSRC = 5'h01, IDX_SET = 5'h02, IDX_VTRIM = 5'h03;
   localparam logic [4:0] IDX_CEIL = 5'h04, IDX_MHI = 5'h05, IDX_MLO = 5'h06, IDX_SLEW = 5'h07;
   localparam logic [4:0] IDX_DROOP = 5'h08, IDX_FREQ = 5'h09, IDX_PHASE = 5'h0a;
   localparam logic [4:0] IDX_GAIN = 5'h0b, IDX_CTRIM = 5'h0c, IDX_OVF = 5'h0d, IDX_OVA = 5'h0e;
   localparam logic [4:0] IDX_OVW = 5'h0f, IDX_UVW = 5'h10, IDX_UVF = 5'h11, IDX_UVA = 5'h12;
   localparam logic [4:0] IDX_OC = 5'h13, IDX_UC = 5'h14, IDX_OT = 5'h15;
   localparam logic [4:0] IDX_NONE = 5'h1f;

   // ----------------------------------------
   // reset values and fields
   // ----------------------------------------
   localparam logic [15:0] RST_RUN = 16'h0000;
   localparam logic [15:0] RST_ONSRC = 16'h0017;
   localparam logic [15:0] VOUT_FMT_VAL = 16'h0013;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_SLEW = 16'hba00;
   localparam logic [15:0] RST_GAIN = 16'hb2ae;
   localparam logic [15:0] RST_ACTION = 16'h0080;
   localparam logic [15:0] RST_OC = 16'he280;
   localparam logic [15:0] RST_UC = 16'he57f;
   localparam logic [15:0] RST_OT = 16'hebe8;
   localparam logic [31:0] PCT_CEIL = 32'd110, PCT_MHI = 32'd105, PCT_MLO = 32'd95;
   localparam logic [31:0] PCT_OVF = 32'd115, PCT_OVW = 32'd110, PCT_UVW = 32'd90;
   localparam logic [31:0] PCT_UVF = 32'd85, PCT_FULL = 32'd100;
   localparam int RUN_ON_BIT = 7;
   localparam int MARGIN_MSB = 5;
   localparam int MARGIN_LSB = 4;
   localparam logic [1:0] MARGIN_LOW = 2'b01;
   localparam logic [1:0] MARGIN_HIGH = 2'b10;
   localparam int ONSRC_CFG_BIT = 4;
   localparam int ONSRC_CMD_BIT = 3;
   localparam int ONSRC_PIN_BIT = 2;
   localparam int ONSRC_POL_BIT = 1;
   localparam int Q8_SHIFT = 8;
   // output lsb per mV is 8.192, held as 2097/256
   localparam logic signed [47:0] LSB_PER_MV_Q8 = 48'sd2097;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int RAMP_TICK_NS = 1000;
   localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;

endpackage : rvc_pkg

// *** rvc_command_bank.sv ***
// regulator configuration command bank with output ramp and fault limits
// What this block does
// - run control byte holds enable and nominal, margin high, margin low modes
// - on/off source byte picks pin and/or command control, default 17h
// - store-all saves every setting written since last store or restore
// - restore-all reloads active settings from the stored copy
// - output voltage format reads 13h, linear with exponent -13
// - setpoint is read/write, reset value taken from the voltage strap
// - signed trim word is added to the selected setpoint or margin word, resets to zero
// - ceiling limits the commanded voltage, defaults to 110% of strap
// - margin high and low words, 105% and 95% of strap, used in margin modes
// - output ramps at the programmed slew rate, default 1 V/ms
// - load-line word lowers output per ampere, resets to zero
// - phase offset follows bus address until software writes it
// - current-sense gain holds winding resistance, resets to 0.67 milliohm
// - current-sense trim is added to measured current, resets to zero
// - overcurrent fault when average current exceeds threshold, default 40 A
// - undercurrent fault when average current falls below threshold, default -40 A
// - over-temperature fault when temperature exceeds threshold, default 125 C
`timescale 1ns/100ps
`default_nettype none

module rvc_command_bank
   import rvc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic [7:0] cmdCode,
   input wire logic [15:0] cmdData,
   input wire logic [15:0] strapVout,
   input wire logic [15:0] strapFreq,
   input wire logic [6:0] busAddr,
   input wire logic enablePin,
   input wire logic [15:0] measCurrent,
   input wire logic [15:0] measTemp,
   output logic rspValid_q,
   output logic rspError_q,
   output logic [15:0] rspData_q,
   output logic outputOn_q,
   output logic [15:0] voutNow_q,
   output logic [15:0] switchRate_q,
   output logic [15:0] phaseOffset_q,
   output logic [15:0] senseGain_q,
   output logic ocFault_q,
   output logic ucFault_q,
   output logic otFault_q
);
   import rvc_pkg::*;

   // ----------------------------------------
   // helper functions
   // ----------------------------------------

   // linear word to signed fixed point with 8 fraction bits
   function automatic logic signed [31:0] linToQ8(input logic [15:0] w);
      logic signed [4:0] expo;
      logic signed [31:0] mant;
      int sh;
      expo = signed'(w[15:11]);
      mant = 32'(signed'(w[10:0]));
      sh = int'(expo) + Q8_SHIFT;
      if (sh >= 0)
      begin
         return mant <<< sh;
      end
      return mant >>> (-sh);
   endfunction : linToQ8

   // percentage of the strapped voltage
   function automatic logic [15:0] pctOf(input logic [15:0] v, input logic [31:0] pct);
      logic [31:0] prod;
      prod = {16'h0000, v} * pct;
      return 16'(prod / PCT_FULL);
   endfunction : pctOf

   // command code to register slot
   function automatic logic [4:0] slotOf(input logic [7:0] code);
      unique case (code)
         CMD_RUN_CTRL: return IDX_RUN;
         CMD_ON_SRC: return IDX_ONSRC;
         CMD_SETPOINT: return IDX_SET;
         CMD_VTRIM: return IDX_VTRIM;
         CMD_CEILING: return IDX_CEIL;
         CMD_MARGIN_HI: return IDX_MHI;
         CMD_MARGIN_LO: return IDX_MLO;
         CMD_SLEW: return IDX_SLEW;
         CMD_LOAD_LINE: return IDX_DROOP;
         CMD_SW_RATE: return IDX_FREQ;
         CMD_PHASE: return IDX_PHASE;
         CMD_CS_GAIN: return IDX_GAIN;
         CMD_CS_TRIM: return IDX_CTRIM;
         CMD_OV_FLT: return IDX_OVF;
         CMD_OV_ACT: return IDX_OVA;
         CMD_OV_WARN: return IDX_OVW;
         CMD_UV_WARN: return IDX_UVW;
         CMD_UV_FLT: return IDX_UVF;
         CMD_UV_ACT: return IDX_UVA;
         CMD_OC_FLT: return IDX_OC;
         CMD_UC_FLT: return IDX_UC;
         CMD_OT_FLT: return IDX_OT;
         default: return IDX_NONE;
      endcase
   endfunction : slotOf

   // byte-wide slots keep their upper byte at zero
   function automatic logic isByteSlot(input logic [4:0] s);
      return (s == IDX_RUN) || (s == IDX_ONSRC) || (s == IDX_OVA) || (s == IDX_UVA);
   endfunction : isByteSlot

   // reset value of each slot; strap-derived slots are loaded after release
   function automatic logic [15:0] resetOf(input int s);
      unique case (s)
         int'(IDX_RUN): return RST_RUN;
         int'(IDX_ONSRC): return RST_ONSRC;
         int'(IDX_SLEW): return RST_SLEW;
         int'(IDX_GAIN): return RST_GAIN;
         int'(IDX_OVA), int'(IDX_UVA): return RST_ACTION;
         int'(IDX_OC): return RST_OC;
         int'(IDX_UC): return RST_UC;
         int'(IDX_OT): return RST_OT;
         default: return RST_ZERO;
      endcase
   endfunction : resetOf

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic [15:0] regs_q [NREG];
   logic [15:0] stored_q [NREG];
   logic [NREG-1:0] dirty_q;
   logic [NREG-1:0] storedValid_q;
   logic strapDone_q;
   logic phaseWritten_q;
   logic [4:0] slot;
   logic slotHit;
   logic wrHit;
   logic storeCmd;
   logic restoreCmd;
   logic clearCmd;
   logic [15:0] wrValue;

   assign slot = slotOf(cmdCode);
   assign slotHit = (slot != IDX_NONE);
   assign wrHit = cmdValid && cmdWrite && slotHit && strapDone_q;
   assign storeCmd = cmdValid && cmdWrite && (cmdCode == CMD_STORE_ALL);
   assign restoreCmd = cmdValid && cmdWrite && (cmdCode == CMD_RESTORE_ALL);
   assign clearCmd = cmdValid && cmdWrite && (cmdCode == CMD_CLR_FAULT);
   assign wrValue = isByteSlot(slot) ? {8'h00, cmdData[7:0]} : cmdData;

   // strap capture one cycle after reset release
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         strapDone_q <= 1'b0;
      else
         strapDone_q <= 1'b1;
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------

   // reset, strap load, host writes and restore
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NREG; i++)
            regs_q[i] <= resetOf(i);
      end
      else if (!strapDone_q)
      begin
         regs_q[IDX_SET] <= strapVout;
         regs_q[IDX_CEIL] <= pctOf(strapVout, PCT_CEIL);
         regs_q[IDX_MHI] <= pctOf(strapVout, PCT_MHI);
         regs_q[IDX_MLO] <= pctOf(strapVout, PCT_MLO);
         regs_q[IDX_OVF] <= pctOf(strapVout, PCT_OVF);
         regs_q[IDX_OVW] <= pctOf(strapVout, PCT_OVW);
         regs_q[IDX_UVW] <= pctOf(strapVout, PCT_UVW);
         regs_q[IDX_UVF] <= pctOf(strapVout, PCT_UVF);
         regs_q[IDX_FREQ] <= strapFreq;
      end
      else if (wrHit)
         regs_q[slot] <= wrValue;
      else if (restoreCmd)
      begin
         for (int i = 0; i < NREG; i++)
            if (storedValid_q[i])
               regs_q[i] <= stored_q[i];
      end
   end

   // nonvolatile copy and written-since-last-store-or-restore tracking
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dirty_q <= '0;
         storedValid_q <= '0;
         for (int i = 0; i < NREG; i++)
            stored_q[i] <= RST_ZERO;
      end
      else if (wrHit)
         dirty_q[slot] <= 1'b1;
      else if (storeCmd)
      begin
         for (int i = 0; i < NREG; i++)
            if (dirty_q[i])
               stored_q[i] <= regs_q[i];
         storedValid_q <= storedValid_q | dirty_q;
         dirty_q <= '0;
      end
      else if (restoreCmd)
         dirty_q <= '0;
   end

   // phase offset follows the address until software writes it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         phaseWritten_q <= 1'b0;
      else if (wrHit && (slot == IDX_PHASE))
         phaseWritten_q <= 1'b1;
   end

   // read answer, one cycle after the command
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rspValid_q <= 1'b0;
         rspError_q <= 1'b0;
         rspData_q <= RST_ZERO;
      end
      else
      begin
         rspValid_q <= cmdValid;
         rspError_q <= cmdValid && !slotHit && (cmdWrite ? !(storeCmd || restoreCmd || clearCmd)
                                                         : (cmdCode != CMD_VOUT_FMT));
         if (cmdValid && !cmdWrite && (cmdCode == CMD_VOUT_FMT))
            rspData_q <= VOUT_FMT_VAL;
         else if (cmdValid && !cmdWrite && slotHit)
            rspData_q <= regs_q[slot];
         else
            rspData_q <= RST_ZERO;
      end
   end

   // ----------------------------------------
   // output voltage target
   // ----------------------------------------
   logic [1:0] marginMode;
   logic [15:0] selected;
   logic signed [47:0] currQ8;
   logic signed [47:0] dropLsb;
   logic signed [47:0] trimmed;
   logic [15:0] target_q;

   assign marginMode = regs_q[IDX_RUN][MARGIN_MSB:MARGIN_LSB];
   assign currQ8 = 48'(linToQ8(measCurrent)) + 48'(linToQ8(regs_q[IDX_CTRIM]));
   // load-line drop in output lsb: mV/A times A, then mV to lsb
   assign dropLsb = ((48'(linToQ8(regs_q[IDX_DROOP])) * currQ8) >>> Q8_SHIFT)
                    * LSB_PER_MV_Q8 >>> (2 * Q8_SHIFT);

   // margin select, trim, droop
   always_comb
   begin
      unique case (marginMode)
         MARGIN_HIGH: selected = regs_q[IDX_MHI];
         MARGIN_LOW: selected = regs_q[IDX_MLO];
         default: selected = regs_q[IDX_SET];
      endcase
      trimmed = 48'(selected) + 48'(signed'(regs_q[IDX_VTRIM])) - dropLsb;
   end

   // clamp to ceiling and floor of zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         target_q <= RST_ZERO;
      else if (trimmed < 48'sd0)
         target_q <= RST_ZERO;
      else if (trimmed > 48'(regs_q[IDX_CEIL]))
         target_q <= regs_q[IDX_CEIL];
      else
         target_q <= 16'(trimmed);
   end

   // ----------------------------------------
   // slew ramp
   // ----------------------------------------
   logic [6:0] tickCnt_q;
   logic tick;
   logic signed [31:0] stepQ8;
   logic [31:0] accQ8_q;
   logic [31:0] accSum;
   logic [15:0] moveLsb;
   logic [15:0] gap;

   assign tick = (tickCnt_q == 7'(RAMP_TICK_CYC - 1));
   // V/ms to output lsb per microsecond, 8 fraction bits
   assign stepQ8 = 32'((48'(linToQ8(regs_q[IDX_SLEW])) * LSB_PER_MV_Q8) >>> Q8_SHIFT);
   assign accSum = accQ8_q + (stepQ8[31] ? 32'h0000_0000 : stepQ8);
   assign moveLsb = (accSum[31:Q8_SHIFT] > 24'(16'hffff)) ? 16'hffff : 16'(accSum[31:Q8_SHIFT]);
   assign gap = (voutNow_q > target_q) ? (voutNow_q - target_q) : (target_q - voutNow_q);

   // one microsecond ramp tick
   always_ff @(posedge clk)
   begin
      if (!rst_n || tick)
         tickCnt_q <= '0;
      else
         tickCnt_q <= tickCnt_q + 7'd1;
   end

   // step toward target, keeping the fraction between ticks
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         voutNow_q <= RST_ZERO;
         accQ8_q <= '0;
      end
      else if (tick)
      begin
         if (gap <= moveLsb)
         begin
            voutNow_q <= target_q;
            accQ8_q <= '0;
         end
         else
         begin
            voutNow_q <= (voutNow_q > target_q) ? voutNow_q - moveLsb : voutNow_q + moveLsb;
            accQ8_q <= {24'h00_0000, accSum[Q8_SHIFT-1:0]};
         end
      end
   end

   // ----------------------------------------
   // enable, configuration outputs
   // ----------------------------------------
   logic [15:0] onSrc;
   logic pinOk;
   logic cmdOk;

   assign onSrc = regs_q[IDX_ONSRC];
   assign pinOk = !onSrc[ONSRC_PIN_BIT] || (enablePin == onSrc[ONSRC_POL_BIT]);
   assign cmdOk = !onSrc[ONSRC_CMD_BIT] || regs_q[IDX_RUN][RUN_ON_BIT];

   // turn-on source selection and pass-through of settings
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         outputOn_q <= 1'b0;
         switchRate_q <= RST_ZERO;
         phaseOffset_q <= RST_ZERO;
         senseGain_q <= RST_GAIN;
      end
      else
      begin
         outputOn_q <= !onSrc[ONSRC_CFG_BIT] || (pinOk && cmdOk);
         switchRate_q <= regs_q[IDX_FREQ];
         phaseOffset_q <= phaseWritten_q ? regs_q[IDX_PHASE] : {12'h000, busAddr[3:0]};
         senseGain_q <= regs_q[IDX_GAIN];
      end
   end

   // ----------------------------------------
   // fault flags, sticky until clear-faults
   // ----------------------------------------
   logic ocNow;
   logic ucNow;
   logic otNow;

   assign ocNow = currQ8 > 48'(linToQ8(regs_q[IDX_OC]));
   assign ucNow = currQ8 < 48'(linToQ8(regs_q[IDX_UC]));
   assign otNow = linToQ8(measTemp) > linToQ8(regs_q[IDX_OT]);

   // set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ocFault_q <= 1'b0;
         ucFault_q <= 1'b0;
         otFault_q <= 1'b0;
      end
      else
      begin
         ocFault_q <= ocNow || (ocFault_q && !clearCmd);
         ucFault_q <= ucNow || (ucFault_q && !clearCmd);
         otFault_q <= otNow || (otFault_q && !clearCmd);
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_fmtRead;
      cmdValid && !cmdWrite && (cmdCode == CMD_VOUT_FMT);
   endsequence

   sequence s_store;
      storeCmd;
   endsequence

   property p_fmtRead;
      @(posedge clk) disable iff (!rst_n) s_fmtRead |=> rspValid_q && rspData_q == 16'h0013;
   endproperty
   a_fmtRead: assert property (p_fmtRead) else $error("format read wrong");

   property p_runWrite;
      @(posedge clk) disable iff (!rst_n)
         wrHit && slot == IDX_RUN |=> regs_q[IDX_RUN] == {8'h00, $past(cmdData[7:0])};
   endproperty
   a_runWrite: assert property (p_runWrite) else $error("run control write lost");

   property p_ceiling;
      @(posedge clk) disable iff (!rst_n) strapDone_q |=> target_q <= $past(regs_q[IDX_CEIL]);
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("target above ceiling");

   property p_marginHigh;
      @(posedge clk) disable iff (!rst_n)
         strapDone_q && marginMode == MARGIN_HIGH && !regs_q[IDX_VTRIM][15] && dropLsb == 48'sd0
         && ({1'b0, regs_q[IDX_MHI]} + {1'b0, regs_q[IDX_VTRIM]}) <= {1'b0, regs_q[IDX_CEIL]}
         |=> target_q == $past(regs_q[IDX_MHI]) + $past(regs_q[IDX_VTRIM]);
   endproperty
   a_marginHigh: assert property (p_marginHigh) else $error("margin high not used");

   property p_rampTick;
      @(posedge clk) disable iff (!rst_n) !tick |=> $stable(voutNow_q);
   endproperty
   a_rampTick: assert property (p_rampTick) else $error("ramp moved off tick");

   property p_overCurrent;
      @(posedge clk) disable iff (!rst_n)
         ocNow |=> ocFault_q ##1 (ocFault_q || $past(clearCmd));
   endproperty
   a_overCurrent: assert property (p_overCurrent) else $error("overcurrent not flagged");

   property p_underCurrent;
      @(posedge clk) disable iff (!rst_n) ucNow |=> ucFault_q;
   endproperty
   a_underCurrent: assert property (p_underCurrent) else $error("undercurrent not flagged");

   property p_overTemp;
      @(posedge clk) disable iff (!rst_n) otFault_q && !otNow && clearCmd |=> !otFault_q;
   endproperty
   a_overTemp: assert property (p_overTemp) else $error("temperature fault not cleared");

   property p_store;
      @(posedge clk) disable iff (!rst_n)
         s_store |=> dirty_q == '0 && (storedValid_q & $past(dirty_q)) == $past(dirty_q);
   endproperty
   a_store: assert property (p_store) else $error("store did not capture");

   property p_restore;
      @(posedge clk) disable iff (!rst_n)
         restoreCmd && storedValid_q[IDX_VTRIM]
         |=> regs_q[IDX_VTRIM] == $past(stored_q[IDX_VTRIM]);
   endproperty
   a_restore: assert property (p_restore) else $error("restore did not reload");

   property p_alwaysOn;
      @(posedge clk) disable iff (!rst_n) !onSrc[ONSRC_CFG_BIT] |=> outputOn_q;
   endproperty
   a_alwaysOn: assert property (p_alwaysOn) else $error("unit off without control");

   property p_phaseAddr;
      @(posedge clk) disable iff (!rst_n)
         !phaseWritten_q |=> phaseOffset_q == {12'h000, $past(busAddr[3:0])};
   endproperty
   a_phaseAddr: assert property (p_phaseAddr) else $error("phase not from address");

endmodule : rvc_command_bank

`default_nettype wire

// *** rvc_host_model.sv ***
// host model driving the bank's command port
`timescale 1ns/100ps
`default_nettype none
module rvc_host_model
(
   input wire logic clk,
   output logic cmdValid,
   output logic cmdWrite,
   output logic [7:0] cmdCode,
   output logic [15:0] cmdData,
   input wire logic rspValid_q,
   input wire logic rspError_q,
   input wire logic [15:0] rspData_q
);
   // idle port at time zero
   initial
   begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdCode = 8'h00;
      cmdData = 16'h0000;
   end
   // one command, answer taken 1 ns after the edge that accepts it
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] v,
      output logic [15:0] rd, output logic er, output logic ok);
   begin
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdCode <= c;
      cmdData <= v;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdData <= ~v; // stale data never lingers
      #1;
      ok = rspValid_q;
      er = rspError_q;
      rd = rspData_q;
   end
   endtask : xfer
endmodule : rvc_host_model
`default_nettype wire

// *** rvc_command_bank_tb_top.sv ***
// self-checking bench for the command bank
`timescale 1ns/100ps
`default_nettype none
module rvc_command_bank_tb_top;
   import rvc_pkg::*;
   // ----------------------------------------
   // signals, tasks and test sequence
   // ----------------------------------------
   localparam logic [15:0] SV = 16'h2000;
   localparam logic [15:0] SF = 16'h0190;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic enablePin = 1'b1;
   logic [15:0] measCurrent = 16'h0000;
   logic [15:0] measTemp = 16'h0000;
   logic cmdValid, cmdWrite, rspValid_q, rspError_q, outputOn_q, ocFault_q, ucFault_q, otFault_q;
   logic [7:0] cmdCode;
   logic [15:0] cmdData, rspData_q, voutNow_q, switchRate_q, phaseOffset_q, senseGain_q, d;
   logic e, ok;
   logic [7:0] rc [23];
   logic [15:0] re [23];
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   rvc_host_model u_rvc_host_model
   (
      .clk, .cmdValid, .cmdWrite, .cmdCode, .cmdData, .rspValid_q, .rspError_q, .rspData_q
   );
   rvc_command_bank u_rvc_command_bank
   (
      .clk, .rst_n, .cmdValid, .cmdWrite, .cmdCode, .cmdData, .strapVout(SV), .strapFreq(SF),
      .busAddr(7'h25), .enablePin, .measCurrent, .measTemp, .rspValid_q, .rspError_q,
      .rspData_q, .outputOn_q, .voutNow_q, .switchRate_q, .phaseOffset_q, .senseGain_q,
      .ocFault_q, .ucFault_q, .otFault_q
   );
   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 9000)
      begin
         errors++;
         wrap_up();
      end
   end
   function automatic logic [15:0] pc(input int p);
      return 16'((32'(SV) * p) / 100);
   endfunction : pc
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
   begin
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask : chk
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] v);
   begin
      u_rvc_host_model.xfer(w, c, v, d, e, ok);
      chk({15'h0000, ok}, 16'h0001);
   end
   endtask : cmd
   task automatic pause(input int n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask : pause
   task automatic wrap_up();
   begin
      if (errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask : wrap_up
   // main sequence
   initial
   begin
      rc = '{CMD_RUN_CTRL, CMD_ON_SRC, CMD_VOUT_FMT, CMD_SETPOINT, CMD_VTRIM, CMD_CEILING,
         CMD_MARGIN_HI, CMD_MARGIN_LO, CMD_SLEW, CMD_LOAD_LINE, CMD_SW_RATE, CMD_PHASE,
         CMD_CS_GAIN, CMD_CS_TRIM, CMD_OV_FLT, CMD_OV_ACT, CMD_OV_WARN, CMD_UV_WARN,
         CMD_UV_FLT, CMD_UV_ACT, CMD_OC_FLT, CMD_UC_FLT, CMD_OT_FLT};
      re = '{16'h0000, 16'h0017, 16'h0013, SV, 16'h0000, pc(110), pc(105), pc(95), 16'hba00,
         16'h0000, SF, 16'h0000, 16'hb2ae, 16'h0000, pc(115), 16'h0080, pc(110), pc(90),
         pc(85), 16'h0080, 16'he280, 16'he57f, 16'hebe8};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      pause(3);
      chk(senseGain_q, 16'hb2ae);
      chk(phaseOffset_q, 16'h0005);
      chk(switchRate_q, SF);
      for (int i = 0; i < 23; i++)
      begin
         cmd(1'b0, rc[i], 16'h0000);
         chk(d, re[i]);
      end
      cmd(1'b1, CMD_VOUT_FMT, 16'h0055);
      chk({15'h0000, e}, 16'h0001);
      cmd(1'b0, CMD_VOUT_FMT, 16'h0000);
      chk(d, 16'h0013);
      cmd(1'b1, CMD_PHASE, 16'h0003);
      pause(2);
      chk(phaseOffset_q, 16'h0003);
      cmd(1'b1, CMD_VTRIM, 16'h0004);
      cmd(1'b1, CMD_STORE_ALL, 16'h0000);
      cmd(1'b1, CMD_VTRIM, 16'h0009);
      cmd(1'b1, CMD_RESTORE_ALL, 16'h0000);
      cmd(1'b0, CMD_VTRIM, 16'h0000);
      chk(d, 16'h0004);
      cmd(1'b1, CMD_SLEW, 16'h0100);
      cmd(1'b1, CMD_SETPOINT, 16'h1f00);
      pause(1000);
      chk(voutNow_q, 16'h1f04);
      cmd(1'b1, CMD_RUN_CTRL, 16'h0020);
      cmd(1'b0, CMD_RUN_CTRL, 16'h0000);
      chk(d, 16'h0020);
      pause(1000);
      chk(voutNow_q, pc(105) + 16'h0004);
      cmd(1'b1, CMD_CEILING, 16'h2100);
      pause(1000);
      chk(voutNow_q, 16'h2100);
      cmd(1'b1, CMD_RUN_CTRL, 16'h0010);
      pause(1000);
      chk(voutNow_q, pc(95) + 16'h0004);
      @(posedge clk) enablePin <= 1'b0;
      pause(3);
      chk({15'h0000, outputOn_q}, 16'h0000);
      cmd(1'b1, CMD_ON_SRC, 16'h0000);
      pause(2);
      chk({15'h0000, outputOn_q}, 16'h0001);
      cmd(1'b1, CMD_ON_SRC, 16'h0018);
      pause(2);
      chk({15'h0000, outputOn_q}, 16'h0000);
      cmd(1'b1, CMD_RUN_CTRL, 16'h0090);
      pause(2);
      chk({15'h0000, outputOn_q}, 16'h0001);
      cmd(1'b1, CMD_ON_SRC, 16'h0017);
      @(posedge clk) enablePin <= 1'b1;
      pause(3);
      chk({15'h0000, outputOn_q}, 16'h0001);
      chk({13'h0000, ocFault_q, ucFault_q, otFault_q}, 16'h0000);
      @(posedge clk) measCurrent <= 16'he2c0;
      pause(3);
      chk({13'h0000, ocFault_q, ucFault_q, otFault_q}, 16'h0004);
      @(posedge clk) measCurrent <= 16'he57e;
      pause(3);
      chk({13'h0000, ocFault_q, ucFault_q, otFault_q}, 16'h0006);
      @(posedge clk) measTemp <= 16'hebf0;
      pause(3);
      chk({13'h0000, ocFault_q, ucFault_q, otFault_q}, 16'h0007);
      cmd(1'b1, CMD_CLR_FAULT, 16'h0000);
      chk({15'h0000, e}, 16'h0000);
      pause(2);
      chk({13'h0000, ocFault_q, ucFault_q, otFault_q}, 16'h0003);
      @(posedge clk) measTemp <= 16'h0000;
      pause(2);
      cmd(1'b1, CMD_CLR_FAULT, 16'h0000);
      pause(2);
      chk({13'h0000, ocFault_q, ucFault_q, otFault_q}, 16'h0002);
      wrap_up();
   end
endmodule : rvc_command_bank_tb_top
`default_nettype wire
